/* File: core/srlv_stop_reset_monitor.sv */
// Stop recovery, break exit flag, reset cause, break clear control and low-voltage monitor
`timescale 1ns/1ps
`include "srlv_defines.svh"
// Contract
// - Stop recovery lasts 4096 clocks, or 32 with short recovery option.
// - Recovery counter held cleared while stopped, then times recovery.
// - Break during stop sets break exit flag.
// - Break during wait sets break exit flag.
// - Break exit flag reads one only after break-caused stop/wait exit.
// - Writing zero clears break exit flag; reset clears it too.
// - Reset cause register's six flags clear when software reads it.
// - Power-on reset sets power-on flag, clears others.
// - External pin reset sets pin flag.
// - Watchdog reset sets watchdog flag.
// - Illegal opcode reset sets bad opcode flag.
// - Only illegal-address opcode fetch resets set bad fetch flag.
// - Low-voltage reset sets low-voltage flag.
// - Other modules may clear flags in break only if clear enable set.
// - Low-voltage monitor enabled immediately after reset.
// - Power option enables monitoring; reset option enables low-voltage reset.
// - After low-voltage reset, stay in reset until supply above rising level.
// - Low-voltage reset also drives external reset pin low.
// - Low supply flag sets below falling, clears above rising, else holds.
// - Low-voltage monitor never raises an interrupt.
// - With reset option set, low-voltage reset ends wait mode.
// - With stop and power options set, monitor stays active in stop.
module srlv_stop_reset_monitor (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        porReset,
	input  wire logic        pinReset,
	input  wire logic        watchdogReset,
	input  wire logic        badOpcodeReset,
	input  wire logic        badFetchReset,
	input  wire logic        stopExec,
	input  wire logic        waitExec,
	input  wire logic        wakeEvent,
	input  wire logic        breakIrq,
	input  wire logic        breakState,
	input  wire logic        shortRecoveryOption,
	input  wire logic        monitorPowerOption,
	input  wire logic        monitorResetOption,
	input  wire logic        monitorStopOption,
	input  wire logic        belowFallingTrip,
	input  wire logic        aboveRisingTrip,
	input  wire logic [15:0] busAddr,
	input  wire logic        busRead,
	input  wire logic        busWrite,
	input  wire logic [7:0]  busWdata,
	output logic      [7:0]  busRdata,
	output logic             stopActive,
	output logic             waitActive,
	output logic             recoveryDone,
	output logic             lowVoltReset,
	output logic             resetPinLow,
	output logic             flagClearAllowed
);
	srlv_if recIf ();
	srlv_pkg::srlv_mode_type mode_q;
	srlv_pkg::srlv_mode_type mode_d;
	logic       fallSync1_q;
	logic       fallSync_q;
	logic       riseSync1_q;
	logic       riseSync_q;
	logic       lowSupply_q;
	logic       lvHold_q;
	logic       breakExit_q;
	logic       breakClear_q;
	logic [7:0] cause_q;
	logic [7:0] rdata_d;
	logic       doneQ_q;

	srlv_recovery_counter #(
		.LONG_COUNT  (`SRLV_RECOVERY_LONG),
		.SHORT_COUNT (`SRLV_RECOVERY_SHORT)
	) uRecovery (
		.mclk  (mclk),
		.rst_b (rst_b),
		.port  (recIf)
	);

	// Trip comparators are analog, so synchronise both
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			fallSync1_q <= 1'b0;
			fallSync_q  <= 1'b0;
			riseSync1_q <= 1'b0;
			riseSync_q  <= 1'b0;
		end else begin
			fallSync1_q <= belowFallingTrip;
			fallSync_q  <= fallSync1_q;
			riseSync1_q <= aboveRisingTrip;
			riseSync_q  <= riseSync1_q;
		end
	end

	// Monitor live out of reset; in stop only with stop option
	wire monitorLive = monitorPowerOption &&
		(mode_q != srlv_pkg::SRLV_STOPPED || monitorStopOption);
	wire lowSupply_d = !monitorLive ? lowSupply_q :
		fallSync_q ? 1'b1 : riseSync_q ? 1'b0 : lowSupply_q;
	wire lvTrip = monitorLive && monitorResetOption && fallSync_q;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			lowSupply_q <= 1'b0;
			lvHold_q    <= 1'b0;
		end else begin
			lowSupply_q <= lowSupply_d;
			if (lvTrip)
				lvHold_q <= 1'b1;
			else if (riseSync_q)
				lvHold_q <= 1'b0;
		end
	end

	// Stop and wait sequencing; recovery timed only on stop exit
	wire exitReq = wakeEvent || breakIrq;
	assign recIf.hold     = (mode_q != srlv_pkg::SRLV_RECOVER);
	assign recIf.shortSel = shortRecoveryOption;
	always_comb begin
		mode_d = mode_q;
		unique case (mode_q)
			srlv_pkg::SRLV_RUN: begin
				if (stopExec)
					mode_d = srlv_pkg::SRLV_STOPPED;
				else if (waitExec)
					mode_d = srlv_pkg::SRLV_WAITING;
			end
			srlv_pkg::SRLV_STOPPED: begin
				if (exitReq)
					mode_d = srlv_pkg::SRLV_RECOVER;
			end
			srlv_pkg::SRLV_RECOVER: begin
				if (recIf.done)
					mode_d = srlv_pkg::SRLV_RUN;
			end
			srlv_pkg::SRLV_WAITING: begin
				if (exitReq)
					mode_d = srlv_pkg::SRLV_RUN;
			end
		endcase
		if (lvTrip)
			mode_d = srlv_pkg::SRLV_RUN;
	end

	// Register decode
	wire selLow   = busAddr == `SRLV_ADDR_LOW_SUPPLY;
	wire selExit  = busAddr == `SRLV_ADDR_BREAK_EXIT;
	wire selCause = busAddr == `SRLV_ADDR_RESET_CAUSE;
	wire selClear = busAddr == `SRLV_ADDR_BREAK_CLEAR;
	wire inLowPower = mode_q == srlv_pkg::SRLV_STOPPED || mode_q == srlv_pkg::SRLV_WAITING;
	wire breakExitSet = inLowPower && breakIrq;
	wire breakExitClr = busWrite && selExit && !busWdata[`SRLV_BIT_BREAK_EXIT];
	wire causeRead = busRead && selCause;

	always_comb begin
		rdata_d = 8'h00;
		if (selLow)
			rdata_d[`SRLV_BIT_LOW_SUPPLY] = lowSupply_q;
		else if (selExit)
			rdata_d[`SRLV_BIT_BREAK_EXIT] = breakExit_q;
		else if (selCause)
			rdata_d = cause_q;
		else if (selClear)
			rdata_d[`SRLV_BIT_BREAK_CLEAR] = breakClear_q;
	end

	// Cause flags captured on the first clock after reset release
	logic       captured_q;
	wire  [7:0] causeNow = porReset ? `SRLV_CAUSE_RESET :
		{1'b0, pinReset, watchdogReset, badOpcodeReset, badFetchReset, 3'h0};
	// Own low-voltage reset never passes rst_b, so its cause lands at release
	wire        lvEnd   = lvHold_q && riseSync_q;
	wire  [7:0] lvCause = 8'h01 << `SRLV_BIT_LOW_VOLT;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mode_q       <= srlv_pkg::SRLV_RUN;
			breakExit_q  <= 1'b0;
			breakClear_q <= 1'b0;
			cause_q      <= 8'h00;
			captured_q   <= 1'b0;
			busRdata     <= 8'h00;
			doneQ_q      <= 1'b0;
		end else begin
			mode_q   <= mode_d;
			busRdata <= rdata_d;
			doneQ_q  <= recIf.done && mode_q == srlv_pkg::SRLV_RECOVER;
			if (breakExitSet)
				breakExit_q <= 1'b1;
			else if (breakExitClr)
				breakExit_q <= 1'b0;
			if (busWrite && selClear)
				breakClear_q <= busWdata[`SRLV_BIT_BREAK_CLEAR];
			if (!captured_q) begin
				cause_q    <= causeNow;
				captured_q <= 1'b1;
			end else if (lvEnd)
				cause_q <= lvCause;
			else if (causeRead)
				cause_q <= 8'h00;
		end
	end

	// Low-voltage reset has no interrupt path at all
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			stopActive       <= 1'b0;
			waitActive       <= 1'b0;
			recoveryDone     <= 1'b0;
			lowVoltReset     <= 1'b0;
			resetPinLow      <= 1'b0;
			flagClearAllowed <= 1'b0;
		end else begin
			stopActive       <= mode_d == srlv_pkg::SRLV_STOPPED || mode_d == srlv_pkg::SRLV_RECOVER;
			waitActive       <= mode_d == srlv_pkg::SRLV_WAITING;
			recoveryDone     <= doneQ_q;
			lowVoltReset     <= lvTrip || (lvHold_q && !riseSync_q);
			resetPinLow      <= lvTrip || (lvHold_q && !riseSync_q);
			flagClearAllowed <= breakState && breakClear_q;
		end
	end

	AST_EXIT_SET: assert property (@(posedge mclk) disable iff (!rst_b)
		breakExitSet |=> breakExit_q)
		else $error("break exit flag not set");
	AST_EXIT_CLR: assert property (@(posedge mclk) disable iff (!rst_b)
		breakExitClr && !breakExitSet |=> !breakExit_q)
		else $error("flag not cleared");
	AST_EXIT_KEEP: assert property (@(posedge mclk) disable iff (!rst_b)
		!breakExitSet && !breakExitClr |=> $stable(breakExit_q))
		else $error("break exit flag moved");
	AST_CAUSE_RD: assert property (@(posedge mclk) disable iff (!rst_b)
		causeRead && captured_q && !lvEnd |=> cause_q == 8'h00)
		else $error("cause not cleared");
	AST_CAUSE_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
		captured_q && !causeRead && !lvEnd |=> $stable(cause_q))
		else $error("cause changed");
	AST_POR_CAUSE: assert property (@(posedge mclk) disable iff (!rst_b)
		!captured_q && porReset |=> cause_q == 8'h80)
		else $error("power-on cause wrong");
	AST_PIN_CAUSE: assert property (@(posedge mclk) disable iff (!rst_b)
		!captured_q && !porReset && pinReset |=> cause_q[`SRLV_BIT_PIN])
		else $error("pin cause missing");
	AST_WDOG_CAUSE: assert property (@(posedge mclk) disable iff (!rst_b)
		!captured_q && !porReset && watchdogReset |=> cause_q[`SRLV_BIT_WATCHDOG])
		else $error("watchdog cause missing");
	AST_LOW_SET: assert property (@(posedge mclk) disable iff (!rst_b)
		monitorLive && fallSync_q |=> lowSupply_q)
		else $error("low flag not set");
	AST_LOW_CLR: assert property (@(posedge mclk) disable iff (!rst_b)
		monitorLive && riseSync_q && !fallSync_q |=> !lowSupply_q)
		else $error("low flag not cleared");
	AST_LOW_KEEP: assert property (@(posedge mclk) disable iff (!rst_b)
		!monitorLive |=> $stable(lowSupply_q))
		else $error("low flag moved while monitor off");
	AST_PIN_LOW: assert property (@(posedge mclk) disable iff (!rst_b)
		lvTrip |=> resetPinLow && lowVoltReset)
		else $error("pin not driven");
	AST_HOLD_LV: assert property (@(posedge mclk) disable iff (!rst_b)
		lvHold_q && !riseSync_q |=> lowVoltReset && resetPinLow)
		else $error("reset dropped");
	AST_WAIT_END: assert property (@(posedge mclk) disable iff (!rst_b)
		mode_q == srlv_pkg::SRLV_WAITING && lvTrip |=> !waitActive)
		else $error("wait not ended");
	AST_CLR_GATE: assert property (@(posedge mclk) disable iff (!rst_b)
		!breakClear_q |=> !flagClearAllowed)
		else $error("clear not protected");

	// Helper count for the recovery length, the long one far too deep for a repetition
	logic [12:0] recLen_q;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			recLen_q <= 13'h0000;
		else if (mode_q != srlv_pkg::SRLV_RECOVER)
			recLen_q <= 13'h0000;
		else
			recLen_q <= recLen_q + 13'h0001;
	end
	wire  [12:0] recLenWant = shortRecoveryOption ?
		13'(`SRLV_RECOVERY_SHORT) : 13'(`SRLV_RECOVERY_LONG);

	// Wake, recovery end and supply release, each a single-cycle condition
	sequence stopWakeSeq;
		mode_q == srlv_pkg::SRLV_STOPPED && exitReq && !lvTrip;
	endsequence
	sequence recoveryEndSeq;
		mode_q == srlv_pkg::SRLV_RECOVER && recIf.done && !lvTrip;
	endsequence
	sequence runAgainSeq;
		mode_q == srlv_pkg::SRLV_RUN && !stopActive;
	endsequence
	sequence lvReleaseSeq;
		lvEnd && !lvTrip;
	endsequence

	AST_STOP_WAKE: assert property (@(posedge mclk) disable iff (!rst_b)
		stopWakeSeq |=> mode_q == srlv_pkg::SRLV_RECOVER && stopActive)
		else $error("stop wake not taken");
	AST_REC_END: assert property (@(posedge mclk) disable iff (!rst_b)
		recoveryEndSeq |=> runAgainSeq ##1 recoveryDone)
		else $error("recovery end wrong");
	AST_REC_LEN: assert property (@(posedge mclk) disable iff (!rst_b)
		recoveryEndSeq |-> recLen_q == recLenWant)
		else $error("recovery length wrong");
	AST_LV_RELEASE: assert property (@(posedge mclk) disable iff (!rst_b)
		lvReleaseSeq |=> !lowVoltReset && cause_q == 8'h02)
		else $error("low-voltage release wrong");
endmodule

/* File: core/srlv_defines.svh */
// Offsets, field positions, reset values and timing counts for the stop/reset/low-voltage block
`ifndef SRLV_DEFINES_SVH
`define SRLV_DEFINES_SVH
`define SRLV_ADDR_LOW_SUPPLY     16'hFE0F
`define SRLV_ADDR_BREAK_EXIT     16'hFE00
`define SRLV_ADDR_RESET_CAUSE    16'hFE01
`define SRLV_ADDR_BREAK_CLEAR    16'hFE03
`define SRLV_BIT_LOW_SUPPLY      7
`define SRLV_BIT_BREAK_EXIT      1
`define SRLV_BIT_BREAK_CLEAR     7
`define SRLV_BIT_POWER_ON        7
`define SRLV_BIT_PIN             6
`define SRLV_BIT_WATCHDOG        5
`define SRLV_BIT_BAD_OPCODE      4
`define SRLV_BIT_BAD_FETCH       3
`define SRLV_BIT_LOW_VOLT        1
`define SRLV_RECOVERY_LONG       4096
`define SRLV_RECOVERY_SHORT      32
`define SRLV_CAUSE_RESET         8'h80
`endif

/* File: core/srlv_pkg.sv */
// Types shared by the stop/reset/low-voltage block
package srlv_pkg;
	typedef enum logic [1:0] {
		SRLV_RUN     = 2'b00,
		SRLV_STOPPED = 2'b01,
		SRLV_RECOVER = 2'b10,
		SRLV_WAITING = 2'b11
	} srlv_mode_type;
endpackage

/* File: core/srlv_if.sv */
// Interface between the recovery counter and the main block
`timescale 1ns/1ps
interface srlv_if;
	logic hold;
	logic shortSel;
	logic done;
	modport ctrl (output hold, output shortSel, input done);
	modport cnt (input hold, input shortSel, output done);
endinterface

/* File: core/srlv_recovery_counter.sv */
// Stop recovery timer held cleared while stopped
`timescale 1ns/1ps
`include "srlv_defines.svh"
module srlv_recovery_counter #(
	parameter int LONG_COUNT  = `SRLV_RECOVERY_LONG,
	parameter int SHORT_COUNT = `SRLV_RECOVERY_SHORT
) (
	input  wire logic mclk,
	input  wire logic rst_b,
	srlv_if.cnt       port
);
	logic [12:0] count_q;
	wire  [12:0] limit = port.shortSel ? 13'(SHORT_COUNT) : 13'(LONG_COUNT);
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			count_q <= 13'h0000;
		else if (port.hold)
			count_q <= 13'h0000;
		else if (count_q != limit)
			count_q <= count_q + 13'h0001;
	end
	assign port.done = !port.hold && (count_q == limit);
	AST_HELD_CLEAR: assert property (@(posedge mclk) disable iff (!rst_b)
		port.hold |=> count_q == 13'h0000)
		else $error("counter not cleared");
	AST_SHORT_LEN: assert property (@(posedge mclk) disable iff (!rst_b)
		$fell(port.hold) && port.shortSel |-> ##32 port.done)
		else $error("short recovery length");
endmodule

/* File: test/srlv_supply_model.sv */
// Supply comparator model with hysteresis between the two trip levels
`timescale 1ns/1ps
module srlv_supply_model (
	input  wire logic [1:0] supplyLevel,
	output logic            belowFallingTrip,
	output logic            aboveRisingTrip
);
	// Level 0 above rising, 1 between levels, 2 below falling
	assign belowFallingTrip = (supplyLevel == 2'h2);
	assign aboveRisingTrip  = (supplyLevel == 2'h0);
endmodule

/* File: test/test_srlv_stop_reset_monitor.sv */
// Self-checking bench of the stop/reset/low-voltage block
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin n_mismatch++; \
	$display("wrong value %s expected %h seen %h", nm, ex, gt); end end
module test_srlv_stop_reset_monitor;
	logic        mclk = 1'b0;
	logic        rst_b = 1'b0;
	logic [4:0]  cause = 5'h10;
	logic        stopExec = 1'b0, waitExec = 1'b0, wakeEvent = 1'b0, breakIrq = 1'b0;
	logic        breakState = 1'b0, shortOpt = 1'b1, pwrOpt = 1'b1, rstOpt = 1'b1, stopOpt = 1'b1;
	logic [1:0]  supply = 2'h0;
	logic [15:0] busAddr = 16'h0000;
	logic        busRead = 1'b0, busWrite = 1'b0;
	logic [7:0]  busWdata = 8'h00, busRdata, rd;
	logic        stopActive, waitActive, recoveryDone, lowVoltReset, resetPinLow, flagClearAllowed;
	logic        below, above;
	int          n_mismatch = 0, compares = 0, cycles = 0, n, i;
	srlv_supply_model sup_u (.supplyLevel(supply), .belowFallingTrip(below), .aboveRisingTrip(above));
	srlv_stop_reset_monitor dut_u (.mclk(mclk), .rst_b(rst_b), .porReset(cause[4]),
		.pinReset(cause[3]), .watchdogReset(cause[2]), .badOpcodeReset(cause[1]),
		.badFetchReset(cause[0]), .stopExec(stopExec), .waitExec(waitExec),
		.wakeEvent(wakeEvent), .breakIrq(breakIrq), .breakState(breakState),
		.shortRecoveryOption(shortOpt), .monitorPowerOption(pwrOpt),
		.monitorResetOption(rstOpt), .monitorStopOption(stopOpt),
		.belowFallingTrip(below), .aboveRisingTrip(above), .busAddr(busAddr),
		.busRead(busRead), .busWrite(busWrite), .busWdata(busWdata), .busRdata(busRdata),
		.stopActive(stopActive), .waitActive(waitActive), .recoveryDone(recoveryDone),
		.lowVoltReset(lowVoltReset), .resetPinLow(resetPinLow),
		.flagClearAllowed(flagClearAllowed));
	always #2 mclk = ~mclk;
	// Ceiling covers one long recovery plus margin
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 30000) begin
			n_mismatch++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic rd_reg(input logic [15:0] a, input logic [7:0] ex, input string nm);
		@(posedge mclk) begin busAddr <= a; busRead <= 1'b1; end
		@(posedge mclk) busRead <= 1'b0;
		#1 rd = busRdata;
		`CHK(nm, ex, rd)
	endtask
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk) begin busAddr <= a; busWdata <= d; busWrite <= 1'b1; end
		@(posedge mclk) busWrite <= 1'b0;
	endtask
	task automatic do_reset(input int len, input logic [4:0] c);
		@(posedge mclk) begin rst_b <= 1'b0; cause <= c; end
		repeat (len) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (2) @(posedge mclk);
		cause <= 5'h00;
	endtask
	// Wake from stop and time the recovery from the wake edge
	task automatic recover(input logic s, input int lo);
		@(posedge mclk) begin shortOpt <= s; stopExec <= 1'b1; end
		@(posedge mclk) stopExec <= 1'b0;
		repeat (5) @(posedge mclk);
		#1 `CHK("stopActive", 1'b1, stopActive)
		@(posedge mclk) wakeEvent <= 1'b1;
		@(posedge mclk) wakeEvent <= 1'b0;
		n = 1;
		while (recoveryDone !== 1'b1 && n < 5000) begin
			@(posedge mclk);
			#1 n++;
		end
		// Count plus start edge and two register stages
		`CHK("recovery length", 1'b1, (n == lo + 3))
	endtask
	initial begin
		do_reset(20, 5'h10);
		rd_reg(16'hFE01, 8'h80, "cause after power-on");
		rd_reg(16'hFE01, 8'h00, "cause after read");
		rd_reg(16'hFE00, 8'h00, "break exit reset");
		rd_reg(16'hFE03, 8'h00, "clear control reset");
		rd_reg(16'hFE0F, 8'h00, "low supply reset");
		rd_reg(16'hFE05, 8'h00, "unmapped");
		wr_reg(16'hFE0F, 8'hFF);
		wr_reg(16'hFE01, 8'hFF);
		rd_reg(16'hFE0F, 8'h00, "low supply write ignored");
		rd_reg(16'hFE01, 8'h00, "cause write ignored");
		// Pin, watchdog, opcode and fetch causes in turn
		for (i = 0; i < 4; i++) begin
			do_reset(2, 5'h08 >> i);
			repeat (3) @(posedge mclk);
			rd_reg(16'hFE01, 8'h40 >> i, "cause flag");
			rd_reg(16'hFE01, 8'h00, "cause cleared");
		end
		recover(1'b1, 32);
		recover(1'b0, 4096);
		@(posedge mclk) waitExec <= 1'b1;
		@(posedge mclk) waitExec <= 1'b0;
		#1 `CHK("wait entered", 1'b1, waitActive)
		@(posedge mclk) breakIrq <= 1'b1;
		@(posedge mclk) breakIrq <= 1'b0;
		repeat (3) @(posedge mclk);
		#1 `CHK("waitActive", 1'b0, waitActive)
		rd_reg(16'hFE00, 8'h02, "break exit wait");
		wr_reg(16'hFE00, 8'h00);
		rd_reg(16'hFE00, 8'h00, "break exit cleared");
		@(posedge mclk) begin shortOpt <= 1'b1; stopExec <= 1'b1; end
		@(posedge mclk) stopExec <= 1'b0;
		@(posedge mclk) breakIrq <= 1'b1;
		@(posedge mclk) breakIrq <= 1'b0;
		repeat (60) @(posedge mclk);
		rd_reg(16'hFE00, 8'h02, "break exit stop");
		wr_reg(16'hFE03, 8'h80);
		rd_reg(16'hFE03, 8'h80, "clear control");
		@(posedge mclk) breakState <= 1'b1;
		repeat (2) @(posedge mclk);
		#1 `CHK("flagClearAllowed", 1'b1, flagClearAllowed)
		wr_reg(16'hFE03, 8'h00);
		repeat (2) @(posedge mclk);
		#1 `CHK("flagClearAllowed", 1'b0, flagClearAllowed)
		@(posedge mclk) begin breakState <= 1'b0; supply <= 2'h2; end
		repeat (6) @(posedge mclk);
		#1 `CHK("lowVoltReset", 1'b1, lowVoltReset)
		`CHK("resetPinLow", 1'b1, resetPinLow)
		@(posedge mclk) supply <= 2'h1;
		repeat (6) @(posedge mclk);
		#1 `CHK("lowVoltReset held", 1'b1, lowVoltReset)
		@(posedge mclk) supply <= 2'h0;
		repeat (6) @(posedge mclk);
		#1 `CHK("lowVoltReset end", 1'b0, lowVoltReset)
		`CHK("resetPinLow end", 1'b0, resetPinLow)
		rd_reg(16'hFE01, 8'h02, "cause low voltage");
		// Polled use: flag follows supply, no reset
		@(posedge mclk) begin rstOpt <= 1'b0; supply <= 2'h2; end
		repeat (6) @(posedge mclk);
		#1 `CHK("polled no reset", 1'b0, lowVoltReset)
		rd_reg(16'hFE0F, 8'h80, "low supply set");
		@(posedge mclk) supply <= 2'h1;
		repeat (6) @(posedge mclk);
		rd_reg(16'hFE0F, 8'h80, "low supply hold");
		@(posedge mclk) supply <= 2'h0;
		repeat (6) @(posedge mclk);
		rd_reg(16'hFE0F, 8'h00, "low supply clear");
		// Low-voltage reset ends wait
		@(posedge mclk) begin rstOpt <= 1'b1; waitExec <= 1'b1; end
		@(posedge mclk) waitExec <= 1'b0;
		#1 `CHK("wait before trip", 1'b1, waitActive)
		@(posedge mclk) supply <= 2'h2;
		repeat (6) @(posedge mclk);
		#1 `CHK("wait ended by trip", 1'b0, waitActive)
		`CHK("lowVoltReset in wait", 1'b1, lowVoltReset)
		@(posedge mclk) supply <= 2'h0;
		repeat (6) @(posedge mclk);
		// Monitor in stop only with the stop option
		@(posedge mclk) begin stopOpt <= 1'b0; stopExec <= 1'b1; end
		@(posedge mclk) begin stopExec <= 1'b0; supply <= 2'h2; end
		repeat (6) @(posedge mclk);
		#1 `CHK("stop monitor off", 1'b0, lowVoltReset)
		`CHK("still stopped", 1'b1, stopActive)
		@(posedge mclk) stopOpt <= 1'b1;
		repeat (4) @(posedge mclk);
		#1 `CHK("stop monitor on", 1'b1, lowVoltReset)
		`CHK("stop left by trip", 1'b0, stopActive)
		@(posedge mclk) supply <= 2'h0;
		repeat (6) @(posedge mclk);
		#1 `CHK("stop trip end", 1'b0, lowVoltReset)
		end_sim();
	end
endmodule
